// File: nvsram_dev_model.sv
// Behavioural nonvolatile SRAM seen from its pins: array, shadow, key detector.
// Assumes it shares the controller clock to time its internal cycles.
`timescale 1ns/1ps
module nvsram_dev_model #(
  parameter int SAVE_T = 190,
  parameter int LOAD_T = 45,
  parameter int PWR_T = 35
) (
  input wire logic clk_in,
  input wire logic supply_ok_in,
  input wire logic chip_en_b_in,
  input wire logic write_en_b_in,
  input wire logic out_en_b_in,
  input wire logic [10:0] word_select_inputs_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] data_out,
  output logic drive_out
);
  logic [7:0] sram [2048]; // Volatile array
  logic [7:0] nv [2048]; // Shadow array
  logic [10:0] keys [5] = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0}; // Common key steps
  int step = 0; // Key progress
  int busy = 0; // Cycles left with pins disabled
  logic ce_q = 1'b1;
  logic we_q = 1'b1;
  logic ok_q = 1'b0;
  logic [10:0] a_q;
  logic [7:0] d_q;
  // Shadow starts with a known pattern
  initial for (int i = 0; i < 2048; i++) nv[i] = i[7:0] ^ 8'ha5;
  // Drive only in a read, never while writing or busy
  assign drive_out = !chip_en_b_in && !out_en_b_in && write_en_b_in && busy == 0;
  assign data_out = sram[word_select_inputs_in];
  // Pin history, writes, key detection and internal cycles
  always @(posedge clk_in) begin
    ce_q <= chip_en_b_in;
    we_q <= write_en_b_in;
    a_q <= word_select_inputs_in;
    d_q <= bus_in;
    ok_q <= supply_ok_in;
    if (busy > 0) busy <= busy - 1;
    if (supply_ok_in && !ok_q) begin
      for (int i = 0; i < 2048; i++) sram[i] = nv[i];
      busy <= PWR_T;
    end else if (busy == 0 && !ce_q && !we_q && (chip_en_b_in || write_en_b_in)) begin
      sram[a_q] = d_q;
      step <= 0;
    end else if (busy == 0 && !ce_q && we_q && chip_en_b_in) begin
      if (step == 5 && a_q == 11'h70f && ok_q) begin
        for (int i = 0; i < 2048; i++) nv[i] = 8'hff;
        for (int i = 0; i < 2048; i++) nv[i] = sram[i];
        busy <= SAVE_T;
        step <= 0;
      end else if (step == 5 && a_q == 11'h70e) begin
        for (int i = 0; i < 2048; i++) sram[i] = 8'h00;
        for (int i = 0; i < 2048; i++) sram[i] = nv[i];
        busy <= LOAD_T;
        step <= 0;
      end else if (step < 5 && a_q == keys[step]) step <= step + 1;
      else step <= int'(a_q == 11'h000);
    end
  end
endmodule

// File: nvsram_host_ctrl.sv
// Host controller that drives a 2K x 8 nonvolatile SRAM through its async pins.
// Assumes pins sampled through two flops; supply-level flags come from a monitor pin.
// Operation
// - Host holds address stable across whole write
// - Host drives data before write ends
// - Host keeps output enable high during write
// - Save key: 000,555,2AA,7FF,0F0,70F
// - Reload key: 000,555,2AA,7FF,0F0,70E
// - Key steps are chip-enable reads, write high
// - Host never writing when power-up reload ends
`timescale 1ns/1ps
`include "nvsram_host_map.svh"
module nvsram_host_ctrl #(
  parameter int SAVE_CYCLES = `SAVE_CYC,
  parameter int POWERUP_CYCLES = `POWERUP_CYC,
  parameter int RELOAD_CYCLES = `RELOAD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic req_valid_in,
  input wire nvsram_host_pkg::req_t req_in,
  output logic req_ready_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic supply_ok_in,
  input wire logic [7:0] shared_byte_lines_in,
  output logic chip_en_b_out,
  output logic write_en_b_out,
  output logic out_en_b_out,
  output logic [10:0] word_select_inputs_out,
  output logic [7:0] shared_byte_lines_out,
  output logic shared_byte_lines_oe_out
);
  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_RECOVER = 3'b011,
    ST_WAIT_NV = 3'b100,
    ST_POWERUP = 3'b101
  } state_t;
  state_t state;
  // Latched request
  nvsram_host_pkg::req_t cur;
  // Key step index for save/reload sequences
  logic [2:0] step;
  // Strobe timing counter
  logic [7:0] tick;
  // Pin synchronisers
  logic [7:0] din_meta, din_sync;
  logic ok_meta, ok_sync, ok_prev;
  // Timer control
  logic tmr_load, tmr_done;
  logic [23:0] tmr_count;
  // Current key address
  logic [10:0] key_addr;
  // Strobe cycle count (larger of access and strobe counts) and recovery count at counter width
  localparam logic [7:0] STROBE_T = 8'(`ACCESS_CYC > `STROBE_CYC ? `ACCESS_CYC : `STROBE_CYC);
  localparam logic [7:0] RECOVER_T = 8'(`RECOVER_CYC);

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
      ok_meta <= 1'b0;
      ok_sync <= 1'b0;
      ok_prev <= 1'b0;
    end else begin
      din_meta <= shared_byte_lines_in;
      din_sync <= din_meta;
      ok_meta <= supply_ok_in;
      ok_sync <= ok_meta;
      ok_prev <= ok_sync;
    end
  end

  // Key address for the present step
  always_comb begin
    case (step)
      3'd0: key_addr = `KEY_ADDR_0;
      3'd1: key_addr = `KEY_ADDR_1;
      3'd2: key_addr = `KEY_ADDR_2;
      3'd3: key_addr = `KEY_ADDR_3;
      3'd4: key_addr = `KEY_ADDR_4;
      default: key_addr = (cur.op == nvsram_host_pkg::OP_SAVE) ?
        `KEY_ADDR_SAVE : `KEY_ADDR_RELOAD;
    endcase
  end

  // Wait timer shared by save, reload and power-up reload
  nvsram_wait_timer #(.WIDTH(24)) u_timer (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  // Main sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_POWERUP;
      cur <= '0;
      step <= 3'd0;
      tick <= 8'h00;
      tmr_load <= 1'b0;
      tmr_count <= 24'h000000;
      req_ready_out <= 1'b0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      chip_en_b_out <= 1'b1;
      write_en_b_out <= 1'b1;
      out_en_b_out <= 1'b1;
      word_select_inputs_out <= 11'h000;
      shared_byte_lines_out <= 8'h00;
      shared_byte_lines_oe_out <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      rd_valid_out <= 1'b0;
      // Supply drop: device latches a reload, so wait for power-up reload
      if (!ok_sync && state != ST_POWERUP) begin
        state <= ST_POWERUP;
        req_ready_out <= 1'b0;
        chip_en_b_out <= 1'b1;
        write_en_b_out <= 1'b1;
        out_en_b_out <= 1'b1;
        shared_byte_lines_oe_out <= 1'b0;
      end else begin
        case (state)
          // Hold all strobes high until supply is up and power-up reload done
          ST_POWERUP: begin
            write_en_b_out <= 1'b1;
            chip_en_b_out <= 1'b1;
            if (ok_sync && !ok_prev) begin
              tmr_load <= 1'b1;
              tmr_count <= 24'(POWERUP_CYCLES);
            end else if (ok_sync && ok_prev && tmr_done && !tmr_load) begin
              state <= ST_IDLE;
              req_ready_out <= 1'b1;
            end
          end
          // Take a request
          ST_IDLE: begin
            if (req_valid_in) begin
              // Every request is latched, whatever its op
              cur <= req_in;
              step <= 3'd0;
              req_ready_out <= 1'b0;
              state <= ST_SETUP;
            end
          end
          // Address, data and enables placed on the same edge that lowers the strobe
          ST_SETUP: begin
            tick <= 8'h00;
            state <= ST_STROBE;
            chip_en_b_out <= 1'b0;
            if (cur.op == nvsram_host_pkg::OP_WRITE) begin
              word_select_inputs_out <= cur.addr;
              shared_byte_lines_out <= cur.data;
              shared_byte_lines_oe_out <= 1'b1;
              out_en_b_out <= 1'b1;
              write_en_b_out <= 1'b0;
            end else if (cur.op == nvsram_host_pkg::OP_READ) begin
              word_select_inputs_out <= cur.addr;
              out_en_b_out <= 1'b0;
              write_en_b_out <= 1'b1;
            end else begin
              word_select_inputs_out <= key_addr;
              out_en_b_out <= 1'b1;
              write_en_b_out <= 1'b1;
            end
          end
          // Strobe held low for the access time
          ST_STROBE: begin
            tick <= tick + 8'h01;
            if (tick + 8'h01 >= STROBE_T) begin
              chip_en_b_out <= 1'b1;
              write_en_b_out <= 1'b1;
              out_en_b_out <= 1'b1;
              tick <= 8'h00;
              state <= ST_RECOVER;
              if (cur.op == nvsram_host_pkg::OP_READ) begin
                rd_data_out <= din_sync;
                rd_valid_out <= 1'b1;
              end
            end
          end
          // Release bus, then next key step or finish
          ST_RECOVER: begin
            shared_byte_lines_oe_out <= 1'b0;
            tick <= tick + 8'h01;
            if (tick + 8'h01 >= RECOVER_T) begin
              if (cur.op[1] && step != 3'(`KEY_STEPS - 1)) begin
                step <= step + 3'd1;
                state <= ST_SETUP;
              end else if (cur.op[1]) begin
                tmr_load <= 1'b1;
                tmr_count <= (cur.op == nvsram_host_pkg::OP_SAVE) ?
                  24'(SAVE_CYCLES) : 24'(RELOAD_CYCLES);
                state <= ST_WAIT_NV;
              end else begin
                state <= ST_IDLE;
                req_ready_out <= 1'b1;
              end
            end
          end
          // Device busy with save or reload
          ST_WAIT_NV: begin
            if (tmr_done && !tmr_load) begin
              state <= ST_IDLE;
              req_ready_out <= 1'b1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Outputs float toward the device whenever output enable is low
  a_no_drive_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !out_en_b_out |-> !shared_byte_lines_oe_out) else $error("contention");
  a_write_oe_high: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !write_en_b_out |-> out_en_b_out && shared_byte_lines_oe_out) else $error("write");
  a_key_write_high: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cur.op[1] && !chip_en_b_out |-> write_en_b_out) else $error("key write");
  a_addr_stable: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !chip_en_b_out && $past(!chip_en_b_out) |-> $stable(word_select_inputs_out))
    else $error("addr moved");
  a_no_access_busy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state == ST_WAIT_NV |-> chip_en_b_out) else $error("access while busy");
  a_powerup_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state == ST_POWERUP |=> write_en_b_out) else $error("write at power-up");
  a_key_first: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state == ST_SETUP && cur.op[1] && step == 3'd0 |=> word_select_inputs_out == 11'h000)
    else $error("bad first key");
  a_ready_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    req_ready_out |-> state == ST_IDLE) else $error("ready outside idle");
  c_read: cover property (@(posedge clk_in) disable iff (!rst_b_in) rd_valid_out);
  c_save: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    state == ST_WAIT_NV && cur.op == nvsram_host_pkg::OP_SAVE);
  c_reload: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    state == ST_WAIT_NV && cur.op == nvsram_host_pkg::OP_RELOAD);
endmodule

// File: nvsram_host_map.svh
// Constants for the nonvolatile SRAM host controller: pin timing, key addresses, durations.
// Assumes a 125 MHz controller clock; included by the package and the host controller.
`ifndef NVSRAM_HOST_MAP_SVH
`define NVSRAM_HOST_MAP_SVH
// Clock period in ns
`define CLK_PERIOD_NS 8
// Strobe low time in ns (at least) and its cycle count, rounded up
`define STROBE_NS 30
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Access time in ns (at least) before sampling read data
`define ACCESS_NS 45
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Recovery time between accesses in ns
`define RECOVER_NS 16
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Save duration in ms, reload duration in us, power-up reload duration in us
`define SAVE_DURATION_MS 10
`define RELOAD_DURATION_US 20
`define POWERUP_RELOAD_DURATION_US 550
`define SAVE_CYC (`SAVE_DURATION_MS * 1000000 / `CLK_PERIOD_NS)
`define RELOAD_CYC (`RELOAD_DURATION_US * 1000 / `CLK_PERIOD_NS)
`define POWERUP_CYC (`POWERUP_RELOAD_DURATION_US * 1000 / `CLK_PERIOD_NS)
// Key address sequence, last entry differs for save and reload
`define KEY_ADDR_0 11'h000
`define KEY_ADDR_1 11'h555
`define KEY_ADDR_2 11'h2aa
`define KEY_ADDR_3 11'h7ff
`define KEY_ADDR_4 11'h0f0
`define KEY_ADDR_SAVE 11'h70f
`define KEY_ADDR_RELOAD 11'h70e
`define KEY_STEPS 6
`endif

// File: nvsram_host_pkg.sv
// Types for the nonvolatile SRAM host controller.
// Assumes nvsram_host_map.svh is on the include path.
`include "nvsram_host_map.svh"
package nvsram_host_pkg;
  // Operation codes of a user request
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_SAVE = 2'b10,
    OP_RELOAD = 2'b11
  } op_t;
  // One user request
  typedef struct packed {
    op_t op;
    logic [10:0] addr;
    logic [7:0] data;
  } req_t;
  // Pin group driven toward the memory
  typedef struct packed {
    logic chip_en_b;
    logic write_en_b;
    logic out_en_b;
    logic [10:0] word_select_inputs;
    logic [7:0] byte_out;
    logic byte_oe;
  } pins_t;
endpackage

// File: nvsram_wait_timer.sv
// Down-counting wait timer used to hold off access during save and reload.
// Assumes a load pulse on the same clock; done is a level while count is zero.
`timescale 1ns/1ps
module nvsram_wait_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  output logic done_out
);
  // Remaining cycles
  logic [WIDTH-1:0] remain;

  // Load or count down to zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      remain <= '0;
    end else if (load_in) begin
      remain <= count_in;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // Done while nothing remains
  assign done_out = (remain == '0);

  a_timer_counts: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    load_in && count_in != '0 |=> !done_out) else $error("timer did not start");
endmodule

// File: tb.sv
// Testbench: host controller against the behavioural memory model.
// Assumes shortened wait counts; the data bus level is resolved here.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  nvsram_host_pkg::req_t req = '0;
  logic supply_ok = 1'b0;
  logic ready, rd_valid, ce_b, we_b, oe_b, h_oe, d_drv;
  logic [7:0] rd_data, h_data, d_data, bus, got;
  logic [7:0] last = 8'h00; // Last bus level, inverted while floating
  logic [10:0] addr;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc;
  // 125 MHz clock
  always #4 clk = ~clk;
  // Wire level from both drivers
  assign bus = h_oe ? h_data : d_drv ? d_data : ~last;
  always @(posedge clk) last <= bus;
  nvsram_host_ctrl #(.SAVE_CYCLES(200), .POWERUP_CYCLES(40), .RELOAD_CYCLES(50))
    nvsram_host_ctrl_i (.clk_in(clk), .rst_b_in(rst_b), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(ready), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .supply_ok_in(supply_ok), .shared_byte_lines_in(bus), .chip_en_b_out(ce_b),
    .write_en_b_out(we_b), .out_en_b_out(oe_b), .word_select_inputs_out(addr),
    .shared_byte_lines_out(h_data), .shared_byte_lines_oe_out(h_oe));
  // Model keeps its default busy counts, each a little under the host's wait
  nvsram_dev_model nvsram_dev_model_i (
    .clk_in(clk), .supply_ok_in(supply_ok), .chip_en_b_in(ce_b), .write_en_b_in(we_b),
    .out_en_b_in(oe_b), .word_select_inputs_in(addr), .bus_in(bus), .data_out(d_data),
    .drive_out(d_drv));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait for ready, catching any read byte on the way
  task automatic wait_ready();
    for (cyc = 0; cyc < 3000 && ready !== 1'b1; cyc++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) got = rd_data;
    end
    if (cyc == 3000) begin
      miscompares++;
      $display("ERROR ready expected 1 seen timeout");
      tally_and_finish();
    end
  endtask
  task automatic issue(input nvsram_host_pkg::op_t op, input logic [10:0] a,
                       input logic [7:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, a, d};
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    wait_ready();
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] exp);
    got = 8'hxx;
    issue(nvsram_host_pkg::OP_READ, a, 8'h00);
    check("read data", exp, got);
  endtask
  // Output enable stays high whenever write enable is low
  always @(negedge clk) if (we_b === 1'b0) check("oe in write", 8'h01, {7'h0, oe_b});
  // Supply rise loads the shadow, host waits at least the power-up count
  task automatic t_powerup();
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_ready();
    check("powerup wait", 8'h01, {7'h0, cyc >= 40});
    rd(11'h010, 8'h10 ^ 8'ha5);
    rd(11'h7ff, 8'hff ^ 8'ha5);
  endtask
  // Back-to-back writes at both address ends, then reads
  task automatic t_write_read();
    issue(nvsram_host_pkg::OP_WRITE, 11'h000, 8'h81);
    issue(nvsram_host_pkg::OP_WRITE, 11'h7ff, 8'h7e);
    issue(nvsram_host_pkg::OP_WRITE, 11'h123, 8'h3c);
    rd(11'h000, 8'h81);
    rd(11'h7ff, 8'h7e);
    rd(11'h123, 8'h3c);
  endtask
  // Save, overwrite, reload restores the saved bytes
  task automatic t_save_reload();
    issue(nvsram_host_pkg::OP_SAVE, 11'h000, 8'h00);
    // Six key accesses of nine cycles each come before the save wait itself
    check("save wait", 8'h01, {7'h0, cyc >= 200 + 6 * 9});
    issue(nvsram_host_pkg::OP_WRITE, 11'h123, 8'h00);
    rd(11'h123, 8'h00);
    issue(nvsram_host_pkg::OP_RELOAD, 11'h000, 8'h00);
    check("reload wait", 8'h01, {7'h0, cyc >= 50 + 6 * 9});
    rd(11'h123, 8'h3c);
    rd(11'h7ff, 8'h7e);
  endtask
  // Supply drop forces a fresh power-up load from the shadow
  task automatic t_supply_drop();
    issue(nvsram_host_pkg::OP_WRITE, 11'h123, 8'h77);
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (10) @(posedge clk);
    supply_ok <= 1'b1;
    @(negedge clk);
    wait_ready();
    rd(11'h123, 8'h3c);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_powerup();
    t_write_read();
    t_save_reload();
    t_supply_drop();
    tally_and_finish();
  end
endmodule
